//--- src/updown_reload_timer8.v
// How it works
// - mode bit 7: 0 interval timing (reset), 1 auto-reload timing.
// - direction bits 6:5: 00 up (reset), 01 down; bit 6 set hands direction to pin.
// - pin-controlled direction: pin high counts down, pin low counts up.
// - mode bits 4 and 3 always read one; writes leave them unchanged.
// - clock select: /8192,/2048,/512,/64,/16,/4, subclock/4, event pin; reset 000.
// - event counting uses only rising or only falling pin edge per edge-select bit.
// - counter is written only through reload writes and returns its live value on every read.
// - wrap past ff or 00 sets overflow flag; interval wraps, auto-reload reloads.
// - counter and reload share one address: reads counter, writes reload.
// - every reload write also loads the counter at once; counting continues.
// - auto-reload reloads counter on each wrap, period 1 to 256 input clocks.
// - reset: mode 18, counter and reload 00.
// - clock-stop register bit 1 puts the timer into or out of standby; reset 1.
// - in sub power modes only subclock/4 or event source runs the counter.
// - standby bit 0 stops the timer, 1 (reset) lets it run.
// - overflow flag raises the interrupt only while its enable bit is one.
// - subclock/4 is resynchronised to the system clock, one-clock period error.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "updown_reload_timer8_defines.vh"

module updown_reload_timer8 (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [`TMR_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`TMR_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // pins
    input wire event_input_pin,
    input wire count_direction_pin,
    // clock sources and power state
    input wire subclock_div4,
    input wire sub_power_mode,
    // interrupt
    output wire irq
);

    localparam [7:0] mode_reset = `TMR_RST_MODE;

    // mode register kept without the two fixed bits
    reg reload_mode_select;
    reg direction_by_pin;
    reg direction_soft_select;
    reg [2:0] clock_select;
    reg [7:0] timer_count_value;
    reg [7:0] timer_reload_value;
    reg [7:0] module_clock_stop_one;
    reg timer_overflow_request_flag;
    reg timer_interrupt_enable_bit;
    reg event_edge_select_bit;

    // bus holding state
    reg aw_held;
    reg w_held;
    reg [`TMR_IDX_W-1:0] aw_index;
    reg [7:0] w_byte;
    reg w_lane0;

    // direction pin synchroniser
    reg dir_meta;
    reg dir_sync;

    wire count_tick;
    wire [7:0] timer_mode_control;
    wire timer_standby_bit;
    wire do_write;
    wire wr_mode;
    wire wr_reload;
    wire wr_clkstop;
    wire wr_status;
    wire wr_enable;
    wire wr_edge;
    wire wr_mapped;
    wire [`TMR_IDX_W-1:0] ar_index;
    wire count_down;
    wire run;
    wire wrap;

    reg [7:0] next_count;
    reg [31:0] read_word;
    reg read_hit;

    // counting clock source
    count_clock_select clock_source (
        .aclk(aclk),
        .aresetn(aresetn),
        .clock_select(clock_select),
        .event_edge_select_bit(event_edge_select_bit),
        .sub_power_mode(sub_power_mode),
        .subclock_div4(subclock_div4),
        .event_input_pin(event_input_pin),
        .count_tick(count_tick)
    );

    // axi4-lite write side
    // address and data are taken in either order; one write in flight
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    assign do_write = aw_held & w_held & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_index <= {`TMR_IDX_W{1'b0}};
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_index <= s_axi_awaddr[`TMR_ADDR_W-1:2];
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // registers are one byte wide; only lane 0 carries a write
    assign wr_mode = do_write && w_lane0 && aw_index == `TMR_IDX_MODE;
    assign wr_reload = do_write && w_lane0 && aw_index == `TMR_IDX_COUNT;
    assign wr_clkstop = do_write && w_lane0 && aw_index == `TMR_IDX_CLKSTOP;
    assign wr_status = do_write && w_lane0 && aw_index == `TMR_IDX_IRQ_STATUS;
    assign wr_enable = do_write && w_lane0 && aw_index == `TMR_IDX_IRQ_ENABLE;
    assign wr_edge = do_write && w_lane0 && aw_index == `TMR_IDX_EDGE_SEL;
    assign wr_mapped = aw_index == `TMR_IDX_MODE || aw_index == `TMR_IDX_COUNT
        || aw_index == `TMR_IDX_CLKSTOP || aw_index == `TMR_IDX_IRQ_STATUS
        || aw_index == `TMR_IDX_IRQ_ENABLE || aw_index == `TMR_IDX_EDGE_SEL;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMR_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // control registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            reload_mode_select <= mode_reset[`TMR_BIT_RELOAD_MODE];
            direction_by_pin <= mode_reset[`TMR_BIT_DIR_BY_PIN];
            direction_soft_select <= mode_reset[`TMR_BIT_DIR_SOFT];
            clock_select <= mode_reset[2:0];
            module_clock_stop_one <= `TMR_RST_CLKSTOP;
            timer_interrupt_enable_bit <= 1'b0;
            event_edge_select_bit <= 1'b0;
        end else begin
            if (wr_mode) begin
                // bits 4 and 3 are not stored, so writes cannot move them
                reload_mode_select <= w_byte[`TMR_BIT_RELOAD_MODE];
                direction_by_pin <= w_byte[`TMR_BIT_DIR_BY_PIN];
                direction_soft_select <= w_byte[`TMR_BIT_DIR_SOFT];
                clock_select <= w_byte[2:0];
            end
            if (wr_clkstop) begin
                module_clock_stop_one <= w_byte;
            end
            if (wr_enable) begin
                timer_interrupt_enable_bit <= w_byte[`TMR_BIT_OVF];
            end
            if (wr_edge) begin
                event_edge_select_bit <= w_byte[`TMR_BIT_EDGE];
            end
        end
    end

    assign timer_mode_control = {reload_mode_select, direction_by_pin, direction_soft_select,
        `TMR_FIXED_ONES, clock_select};
    assign timer_standby_bit = module_clock_stop_one[`TMR_BIT_STANDBY];

    // direction pin
    always @(posedge aclk) begin
        if (!aresetn) begin
            dir_meta <= 1'b0;
            dir_sync <= 1'b0;
        end else begin
            dir_meta <= count_direction_pin;
            dir_sync <= dir_meta;
        end
    end

    // pin high means down; soft bit ignored while pin has control
    assign count_down = direction_by_pin ? dir_sync : direction_soft_select;

    // counter
    // standby only freezes counting; registers stay reachable
    assign run = count_tick & timer_standby_bit;
    assign wrap = run && (count_down ? timer_count_value == 8'h00
        : timer_count_value == 8'hff);

    always @* begin
        next_count = timer_count_value;
        if (wrap) begin
            if (reload_mode_select) begin
                next_count = timer_reload_value;
            end else begin
                next_count = count_down ? 8'hff : 8'h00;
            end
        end else if (run) begin
            next_count = count_down ? timer_count_value - 8'h01 : timer_count_value + 8'h01;
        end
    end

    // a reload write beats a same-cycle tick; that tick is dropped
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_count_value <= `TMR_RST_COUNT;
            timer_reload_value <= `TMR_RST_RELOAD;
        end else if (wr_reload) begin
            timer_reload_value <= w_byte;
            timer_count_value <= w_byte;
        end else begin
            timer_count_value <= next_count;
        end
    end

    // interrupt flag: write one to clear, set beats clear
    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_overflow_request_flag <= 1'b0;
        end else if (wrap) begin
            timer_overflow_request_flag <= 1'b1;
        end else if (wr_status && w_byte[`TMR_BIT_OVF]) begin
            timer_overflow_request_flag <= 1'b0;
        end
    end

    assign irq = timer_overflow_request_flag & timer_interrupt_enable_bit;

    // axi4-lite read side
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_index = s_axi_araddr[`TMR_ADDR_W-1:2];

    always @* begin
        read_word = 32'h0000_0000;
        read_hit = 1'b1;
        case (ar_index)
            `TMR_IDX_MODE: read_word[7:0] = timer_mode_control;
            `TMR_IDX_COUNT: read_word[7:0] = timer_count_value;
            `TMR_IDX_CLKSTOP: read_word[7:0] = module_clock_stop_one;
            `TMR_IDX_IRQ_STATUS: read_word[`TMR_BIT_OVF] = timer_overflow_request_flag;
            `TMR_IDX_IRQ_ENABLE: read_word[`TMR_BIT_OVF] = timer_interrupt_enable_bit;
            `TMR_IDX_EDGE_SEL: read_word[`TMR_BIT_EDGE] = event_edge_select_bit;
            default: read_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `TMR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word;
            s_axi_rresp <= read_hit ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // updown_reload_timer8

//--- pkg/updown_reload_timer8_defines.vh
`ifndef UPDOWN_RELOAD_TIMER8_DEFINES_VH
`define UPDOWN_RELOAD_TIMER8_DEFINES_VH

// bus geometry: register index is byte address divided by four
`define TMR_ADDR_W 20
`define TMR_IDX_W 18

// register indices
`define TMR_IDX_MODE 18'h0ffb4
`define TMR_IDX_COUNT 18'h0ffb5
`define TMR_IDX_CLKSTOP 18'h0fffa
`define TMR_IDX_IRQ_STATUS 18'h0ffc0
`define TMR_IDX_IRQ_ENABLE 18'h0ffc1
`define TMR_IDX_EDGE_SEL 18'h0ffc2

// reset values
`define TMR_RST_MODE 8'h18
`define TMR_RST_COUNT 8'h00
`define TMR_RST_RELOAD 8'h00
`define TMR_RST_CLKSTOP 8'hff

// register bit fields: mode, then clock-stop standby, interrupt flag and edge select
`define TMR_BIT_RELOAD_MODE 7
`define TMR_BIT_DIR_BY_PIN 6
`define TMR_BIT_DIR_SOFT 5
`define TMR_FIXED_ONES 2'b11
`define TMR_BIT_STANDBY 1
`define TMR_BIT_OVF 0
`define TMR_BIT_EDGE 0

// clock select codes
`define TMR_SEL_DIV8192 3'h0
`define TMR_SEL_DIV2048 3'h1
`define TMR_SEL_DIV512 3'h2
`define TMR_SEL_DIV64 3'h3
`define TMR_SEL_DIV16 3'h4
`define TMR_SEL_DIV4 3'h5
`define TMR_SEL_SUB4 3'h6
`define TMR_SEL_EVENT 3'h7

// prescaler tap widths: divide by two to the power of the width
`define TMR_PRE_W 13
`define TMR_TAP_8192 13
`define TMR_TAP_2048 11
`define TMR_TAP_512 9
`define TMR_TAP_64 6
`define TMR_TAP_16 4
`define TMR_TAP_4 2

// axi responses
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2

`endif

//--- src/count_clock_select.v
`timescale 1ns/10ps
`include "updown_reload_timer8_defines.vh"

module count_clock_select (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // control
    input wire [2:0] clock_select,
    input wire event_edge_select_bit,
    input wire sub_power_mode,
    // asynchronous sources
    input wire subclock_div4,
    input wire event_input_pin,
    // one-cycle count enable
    output reg count_tick
);

    reg [`TMR_PRE_W-1:0] prescale;
    reg sub_meta, sub_sync, sub_last;
    reg evt_meta, evt_sync, evt_last;
    reg next_tick;
    wire sub_rise;
    wire evt_rise;
    wire evt_fall;

    // free-running divider of the system clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= {`TMR_PRE_W{1'b0}};
        end else begin
            prescale <= prescale + {{(`TMR_PRE_W-1){1'b0}}, 1'b1};
        end
    end

    // subclock edge retimed to aclk; costs up to one aclk of period error
    // event pin retimed the same way so one domain remains
    always @(posedge aclk) begin
        if (!aresetn) begin
            sub_meta <= 1'b0;
            sub_sync <= 1'b0;
            sub_last <= 1'b0;
            evt_meta <= 1'b0;
            evt_sync <= 1'b0;
            evt_last <= 1'b0;
        end else begin
            sub_meta <= subclock_div4;
            sub_sync <= sub_meta;
            sub_last <= sub_sync;
            evt_meta <= event_input_pin;
            evt_sync <= evt_meta;
            evt_last <= evt_sync;
        end
    end

    assign sub_rise = sub_sync & ~sub_last;
    assign evt_rise = evt_sync & ~evt_last;
    assign evt_fall = ~evt_sync & evt_last;

    // tap fires once per period when its low bits are all ones
    always @* begin
        next_tick = 1'b0;
        case (clock_select)
            `TMR_SEL_DIV8192: next_tick = &prescale[`TMR_TAP_8192-1:0];
            `TMR_SEL_DIV2048: next_tick = &prescale[`TMR_TAP_2048-1:0];
            `TMR_SEL_DIV512: next_tick = &prescale[`TMR_TAP_512-1:0];
            `TMR_SEL_DIV64: next_tick = &prescale[`TMR_TAP_64-1:0];
            `TMR_SEL_DIV16: next_tick = &prescale[`TMR_TAP_16-1:0];
            `TMR_SEL_DIV4: next_tick = &prescale[`TMR_TAP_4-1:0];
            `TMR_SEL_SUB4: next_tick = sub_rise;
            `TMR_SEL_EVENT: next_tick = event_edge_select_bit ? evt_rise : evt_fall;
            default: next_tick = 1'b0;
        endcase
        // system-clock taps are dead in sub power modes
        if (sub_power_mode && clock_select != `TMR_SEL_SUB4 && clock_select != `TMR_SEL_EVENT) begin
            next_tick = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            count_tick <= 1'b0;
        end else begin
            count_tick <= next_tick;
        end
    end

endmodule // count_clock_select

//--- verification/updown_reload_timer8_props.sv
`timescale 1ns/10ps
`include "updown_reload_timer8_defines.vh"

module updown_reload_timer8_props (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // read side
    input wire [`TMR_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // write side
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // interrupt
    input wire irq
);
    reg [`TMR_IDX_W-1:0] rd_idx;
    wire rd_known = rd_idx == `TMR_IDX_MODE || rd_idx == `TMR_IDX_COUNT ||
        rd_idx == `TMR_IDX_CLKSTOP || rd_idx == `TMR_IDX_IRQ_STATUS ||
        rd_idx == `TMR_IDX_IRQ_ENABLE || rd_idx == `TMR_IDX_EDGE_SEL;

    // address of the read in flight, only looked at while rvalid
    always @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_idx <= s_axi_araddr[`TMR_ADDR_W-1:2];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_arready_rule: assert property (
        s_axi_arready == !s_axi_rvalid)
        else $error("arready wrong");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
        else $error("write not answered in time");
    a_write_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_fixed_ones: assert property (
        s_axi_rvalid && rd_idx == `TMR_IDX_MODE |-> s_axi_rdata[4:3] == `TMR_FIXED_ONES)
        else $error("mode bits 4:3 not one");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_read_resp: assert property (
        s_axi_rvalid |-> s_axi_rresp == (rd_known ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR)
        && (rd_known || s_axi_rdata == 32'h0))
        else $error("read response wrong");
    a_reset_clears: assert property (disable iff (1'b0)
        !aresetn |=> !s_axi_rvalid && !s_axi_bvalid && !irq)
        else $error("reset did not clear outputs");

    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `TMR_RESP_SLVERR);
endmodule // updown_reload_timer8_props

bind updown_reload_timer8 updown_reload_timer8_props u_props (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .irq);

//--- verification/tb_updown_reload_timer8.sv
`timescale 1ns/10ps
`include "updown_reload_timer8_defines.vh"

module tb_updown_reload_timer8;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [19:0] s_axi_awaddr = 20'h0;
    reg s_axi_awvalid = 1'b0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg [19:0] s_axi_araddr = 20'h0;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    reg event_input_pin = 1'b0;
    reg count_direction_pin = 1'b0;
    reg subclock_div4 = 1'b0;
    reg sub_power_mode = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer bad_count = 0;
    integer checks = 0;
    integer i;
    integer divs [0:5] = '{8192, 2048, 512, 64, 16, 4};
    reg [3:0] sub_cnt = 4'h0;
    reg [1:0] resp;
    reg [31:0] rd;
    reg [7:0] cnt;
    localparam [19:0] A_MODE = {`TMR_IDX_MODE, 2'b00};
    localparam [19:0] A_CNT = {`TMR_IDX_COUNT, 2'b00};
    localparam [19:0] A_STOP = {`TMR_IDX_CLKSTOP, 2'b00};
    localparam [19:0] A_STAT = {`TMR_IDX_IRQ_STATUS, 2'b00};
    localparam [19:0] A_EN = {`TMR_IDX_IRQ_ENABLE, 2'b00};
    localparam [19:0] A_EDGE = {`TMR_IDX_EDGE_SEL, 2'b00};
    localparam [19:0] A_BAD = 20'h00010;

    updown_reload_timer8 dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .event_input_pin, .count_direction_pin, .subclock_div4,
        .sub_power_mode, .irq);

    always #5 aclk = ~aclk;

    // slow subclock stand-in, rising edge every 10 cycles
    always @(posedge aclk) begin
        sub_cnt <= (sub_cnt == 4'd4) ? 4'd0 : sub_cnt + 4'd1;
        if (sub_cnt == 4'd4) begin
            subclock_div4 <= ~subclock_div4;
        end
    end

    task final_report;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    // x on got fails too: the comparison must be exactly one
    task chk_in(input [7:0] got, input [7:0] lo, input [7:0] hi);
        checks = checks + 1;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t count %h outside %h..%h", $time, got, lo, hi);
        end
    endtask

    // ready is sampled at the falling edge, so the handshake edge is known
    task wr(input [19:0] a, input [7:0] d);
        reg ha, hw, da, dw, got;
        da = 0;
        dw = 0;
        got = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(da && dw)) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready === 1'b1;
            hw = s_axi_wvalid && s_axi_wready === 1'b1;
            @(posedge aclk);
            if (ha) begin
                s_axi_awvalid <= 1'b0;
                da = 1;
            end
            if (hw) begin
                s_axi_wvalid <= 1'b0;
                dw = 1;
            end
        end
        while (!got) begin
            @(negedge aclk);
            got = s_axi_bvalid === 1'b1;
            resp = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
    endtask

    task rdr(input [19:0] a);
        reg h;
        h = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!h) begin
            @(negedge aclk);
            h = s_axi_arready === 1'b1;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        h = 0;
        while (!h) begin
            @(negedge aclk);
            h = s_axi_rvalid === 1'b1;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
    endtask

    task rchk(input [19:0] a, input [31:0] exp);
        rdr(a);
        chk(rd, exp);
        chk({30'h0, resp}, {30'h0, `TMR_RESP_OKAY});
    endtask

    // freeze, load, run n cycles, freeze again and read back
    task meas(input [7:0] mode, input [7:0] load, input integer n);
        wr(A_MODE, mode);
        wr(A_STOP, 8'hfd);
        wr(A_CNT, load);
        wr(A_STOP, 8'hff);
        repeat (n) @(posedge aclk);
        wr(A_STOP, 8'hfd);
        rdr(A_CNT);
        cnt = rd[7:0];
    endtask

    task toggle(input integer n);
        repeat (n) begin
            @(posedge aclk);
            event_input_pin <= ~event_input_pin;
            repeat (6) @(posedge aclk);
        end
    endtask

    initial begin
        #800000;
        bad_count = bad_count + 1;
        $display("BAD t=%0t watchdog expired", $time);
        final_report;
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(A_MODE, 32'h18);
        rchk(A_CNT, 32'h0);
        rchk(A_STOP, 32'hff);
        rchk(A_STAT, 32'h0);
        rchk(A_EN, 32'h0);
        rchk(A_EDGE, 32'h0);
        rdr(A_BAD);
        chk({30'h0, resp}, {30'h0, `TMR_RESP_SLVERR});
        wr(A_BAD, 8'h55);
        chk({30'h0, resp}, {30'h0, `TMR_RESP_SLVERR});
        wr(A_MODE, 8'h00);
        rchk(A_MODE, 32'h18);
        wr(A_MODE, 8'he7);
        rchk(A_MODE, 32'hff);
        $display("test reset_and_mode done");
        for (i = 0; i < 6; i = i + 1) begin
            meas({5'h03, i[2:0]}, 8'h00, 4 * divs[i]);
            chk_in(cnt, 8'd3, 8'd7);
        end
        $display("test clock_select done");
        meas(8'h05, 8'h40, 40);
        chk_in(cnt, 8'h48, 8'h50);
        meas(8'h25, 8'h40, 40);
        chk_in(cnt, 8'h30, 8'h38);
        @(posedge aclk) count_direction_pin <= 1'b1;
        meas(8'h45, 8'h40, 40);
        chk_in(cnt, 8'h30, 8'h38);
        @(posedge aclk) count_direction_pin <= 1'b0;
        meas(8'h65, 8'h40, 40);
        chk_in(cnt, 8'h48, 8'h50);
        $display("test direction done");
        wr(A_STAT, 8'h01);
        meas(8'h05, 8'hfe, 40);
        chk_in(cnt, 8'h06, 8'h0e);
        rchk(A_STAT, 32'h1);
        wr(A_STAT, 8'h01);
        rchk(A_STAT, 32'h0);
        meas(8'h25, 8'h01, 40);
        chk_in(cnt, 8'hf1, 8'hf9);
        rchk(A_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(A_EN, 8'h01);
        chk({31'h0, irq}, 32'h1);
        wr(A_EN, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(A_EN, 8'h01);
        wr(A_STAT, 8'h01);
        chk({31'h0, irq}, 32'h0);
        $display("test wrap_and_irq done");
        meas(8'h85, 8'hfc, 40);
        chk_in(cnt, 8'hfc, 8'hff);
        meas(8'ha5, 8'h02, 40);
        chk_in(cnt, 8'h00, 8'h02);
        chk({31'h0, irq}, 32'h1);
        rchk(A_CNT, {24'h0, cnt});
        wr(A_EN, 8'h00);
        $display("test auto_reload done");
        @(posedge aclk) sub_power_mode <= 1'b1;
        meas(8'h05, 8'h40, 40);
        chk({24'h0, cnt}, 32'h40);
        meas(8'h06, 8'h40, 100);
        chk_in(cnt, 8'h48, 8'h4d);
        @(posedge aclk) sub_power_mode <= 1'b0;
        meas(8'h06, 8'h40, 100);
        chk_in(cnt, 8'h48, 8'h4d);
        $display("test subclock done");
        wr(A_MODE, 8'h07);
        wr(A_EDGE, 8'h01);
        wr(A_CNT, 8'h00);
        wr(A_STOP, 8'hff);
        toggle(5);
        repeat (8) @(posedge aclk);
        rchk(A_CNT, 32'h3);
        wr(A_EDGE, 8'h00);
        wr(A_CNT, 8'h00);
        toggle(5);
        repeat (8) @(posedge aclk);
        rchk(A_CNT, 32'h3);
        $display("test events done");
        final_report;
    end
endmodule // tb_updown_reload_timer8
